/* File: verilog/cdcfg_pkg.sv */
// package: register map, field layout, reset values and carriers of the clock distribution config block
package cdcfg_pkg;
    // ==========================================
    // register offsets
    localparam logic [11:0] CDCFG_ADDR_SETTINGS   = 12'h400;
    localparam logic [11:0] CDCFG_ADDR_ENABLE     = 12'h401;
    localparam logic [11:0] CDCFG_ADDR_SYNC       = 12'h402;
    localparam logic [11:0] CDCFG_ADDR_AUTOSYNC   = 12'h403;
    localparam logic [11:0] CDCFG_ADDR_CHMODE0    = 12'h404;
    localparam int          CDCFG_NUM_OUTPUTS     = 4;
    // ==========================================
    // field positions
    localparam int CDCFG_SET_EXT_RES_BIT   = 5;
    localparam int CDCFG_SET_RX_MODE_BIT   = 4;
    localparam int CDCFG_SYNC_SRC_LSB      = 4;
    localparam int CDCFG_CH_PHASE_INV_BIT  = 5;
    localparam int CDCFG_CH_POL_INV_BIT    = 4;
    localparam int CDCFG_CH_DRIVE_BIT      = 3;
    // ==========================================
    // writable masks and reset values
    localparam logic [7:0] CDCFG_MASK_SETTINGS  = 8'h3F;
    localparam logic [7:0] CDCFG_MASK_ENABLE    = 8'h0F;
    localparam logic [7:0] CDCFG_MASK_SYNC      = 8'h3F;
    localparam logic [7:0] CDCFG_MASK_AUTOSYNC  = 8'h03;
    localparam logic [7:0] CDCFG_MASK_CHMODE    = 8'h3F;
    localparam logic [7:0] CDCFG_RST_SETTINGS   = 8'h00;
    localparam logic [7:0] CDCFG_RST_ENABLE     = 8'h00;
    localparam logic [7:0] CDCFG_RST_SYNC       = 8'h00;
    localparam logic [7:0] CDCFG_RST_AUTOSYNC   = 8'h00;
    localparam logic [7:0] CDCFG_RST_CHMODE     = 8'h03;
    // ==========================================
    // encodings
    typedef enum logic [1:0] {
        CDCFG_SYNC_DIRECT   = 2'b00,
        CDCFG_SYNC_ACT_REF  = 2'b01,
        CDCFG_SYNC_FB_EDGE  = 2'b10,
        CDCFG_SYNC_RSVD     = 2'b11
    } cdcfg_sync_src_type;
    typedef enum logic [1:0] {
        CDCFG_AUTO_OFF      = 2'b00,
        CDCFG_AUTO_FREQ     = 2'b01,
        CDCFG_AUTO_PHASE    = 2'b10,
        CDCFG_AUTO_RSVD     = 2'b11
    } cdcfg_auto_type;
    typedef enum logic [2:0] {
        CDCFG_MODE_CMOS_BOTH = 3'b000,
        CDCFG_MODE_CMOS_POS  = 3'b001,
        CDCFG_MODE_CMOS_NEG  = 3'b010,
        CDCFG_MODE_TRISTATE  = 3'b011,
        CDCFG_MODE_LVDS      = 3'b100,
        CDCFG_MODE_LVPECL    = 3'b101,
        CDCFG_MODE_RSVD6     = 3'b110,
        CDCFG_MODE_RSVD7     = 3'b111
    } cdcfg_mode_type;
    // ==========================================
    // per-output control carrier
    typedef struct packed {
        logic power_down;
        logic driver_en;
        logic sync_mask;
        logic polarity_inv;
        logic phase_inv;
        logic drive_strong;
        logic pos_drive;
        logic neg_drive;
        logic lvds_sel;
        logic lvpecl_sel;
    } cdcfg_out_ctrl_type;
endpackage

/* File: verilog/cdcfg_top.sv */
// clock distribution output configuration: register file and decoded per-output controls
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ns
`default_nettype none
module cdcfg_top
    import cdcfg_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input  wire logic                 ref_clk_in,
    input  wire logic                 rst_in,
    input  wire logic [ADDR_W-1:0]    reg_addr_in,
    input  wire logic [7:0]           reg_wdata_in,
    input  wire logic                 reg_wr_in,
    input  wire logic                 reg_rd_in,
    input  wire logic                 freq_lock_in,
    input  wire logic                 phase_lock_in,
    input  wire logic                 sync_request_in,
    output logic [7:0]                reg_rdata_out,
    output logic                      ext_resistor_out,
    output logic                      super_nyquist_out,
    output logic                      deep_sleep_out,
    output cdcfg_sync_src_type        sync_source_out,
    output logic                      divider_sync_out,
    output logic [3:0]                divider_reset_out,
    output cdcfg_out_ctrl_type [3:0]  out_ctrl_out
);
    // ==========================================
    // elaboration check
    if (ADDR_W < 12) begin : g_bad_width
        $error("address width must be at least 12");
    end

    // ==========================================
    // register storage
    logic [7:0] settings_ff;
    logic [7:0] enable_ff;
    logic [7:0] sync_ff;
    logic [7:0] autosync_ff;
    logic [7:0] chmode_ff [CDCFG_NUM_OUTPUTS];
    logic [7:0] rdata_ff;
    logic       freq_lock_s1_ff;
    logic       freq_lock_ff;
    logic       freq_lock_old_ff;
    logic       phase_lock_s1_ff;
    logic       phase_lock_ff;
    logic       phase_lock_old_ff;
    logic       sync_req_s1_ff;
    logic       sync_req_ff;
    logic       sync_req_old_ff;
    logic       sync_pulse_ff;
    logic [3:0] div_reset_ff;

    // address decode
    wire logic [11:0] addr12   = reg_addr_in[11:0];
    wire logic        hi_zero  = (ADDR_W == 12) ? 1'b1 : (reg_addr_in >> 12) == '0;
    wire logic        hit_set  = hi_zero && addr12 == CDCFG_ADDR_SETTINGS;
    wire logic        hit_en   = hi_zero && addr12 == CDCFG_ADDR_ENABLE;
    wire logic        hit_sync = hi_zero && addr12 == CDCFG_ADDR_SYNC;
    wire logic        hit_auto = hi_zero && addr12 == CDCFG_ADDR_AUTOSYNC;
    wire logic [11:0] ch_off   = addr12 - CDCFG_ADDR_CHMODE0;
    wire logic        hit_ch   = hi_zero && addr12 >= CDCFG_ADDR_CHMODE0
                                 && ch_off < 12'(CDCFG_NUM_OUTPUTS);
    wire logic [1:0]  ch_idx   = ch_off[1:0];

    // read mux: unmapped addresses and unused bits read zero
    logic [7:0] nxt_rdata;
    always_comb begin
        nxt_rdata = 8'h00;
        if (hit_set) begin
            nxt_rdata = settings_ff;
        end else if (hit_en) begin
            nxt_rdata = enable_ff;
        end else if (hit_sync) begin
            nxt_rdata = sync_ff;
        end else if (hit_auto) begin
            nxt_rdata = autosync_ff;
        end else if (hit_ch) begin
            nxt_rdata = chmode_ff[ch_idx];
        end
    end

    // register writes, masked to implemented bits
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            settings_ff <= CDCFG_RST_SETTINGS;
            enable_ff   <= CDCFG_RST_ENABLE;
            sync_ff     <= CDCFG_RST_SYNC;
            autosync_ff <= CDCFG_RST_AUTOSYNC;
            for (int i = 0; i < CDCFG_NUM_OUTPUTS; i++) begin
                chmode_ff[i] <= CDCFG_RST_CHMODE;
            end
        end else if (reg_wr_in) begin
            if (hit_set)  settings_ff <= reg_wdata_in & CDCFG_MASK_SETTINGS;
            if (hit_en)   enable_ff   <= reg_wdata_in & CDCFG_MASK_ENABLE;
            if (hit_sync) sync_ff     <= reg_wdata_in & CDCFG_MASK_SYNC;
            if (hit_auto) autosync_ff <= reg_wdata_in & CDCFG_MASK_AUTOSYNC;
            if (hit_ch)   chmode_ff[ch_idx] <= reg_wdata_in & CDCFG_MASK_CHMODE;
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= reg_rd_in ? nxt_rdata : 8'h00;
        end
    end
    assign reg_rdata_out = rdata_ff;

    // ==========================================
    // global settings
    assign ext_resistor_out  = settings_ff[CDCFG_SET_EXT_RES_BIT];
    assign super_nyquist_out = settings_ff[CDCFG_SET_RX_MODE_BIT];
    assign deep_sleep_out    = &settings_ff[3:0];
    assign sync_source_out   = cdcfg_sync_src_type'(sync_ff[CDCFG_SYNC_SRC_LSB +: 2]);

    // ==========================================
    // lock and sync request inputs come from other domains: two-flop synchronise
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            freq_lock_s1_ff   <= 1'b0;
            freq_lock_ff      <= 1'b0;
            freq_lock_old_ff  <= 1'b0;
            phase_lock_s1_ff  <= 1'b0;
            phase_lock_ff     <= 1'b0;
            phase_lock_old_ff <= 1'b0;
            sync_req_s1_ff    <= 1'b0;
            sync_req_ff       <= 1'b0;
            sync_req_old_ff   <= 1'b0;
        end else begin
            freq_lock_s1_ff   <= freq_lock_in;
            freq_lock_ff      <= freq_lock_s1_ff;
            freq_lock_old_ff  <= freq_lock_ff;
            phase_lock_s1_ff  <= phase_lock_in;
            phase_lock_ff     <= phase_lock_s1_ff;
            phase_lock_old_ff <= phase_lock_ff;
            sync_req_s1_ff    <= sync_request_in;
            sync_req_ff       <= sync_req_s1_ff;
            sync_req_old_ff   <= sync_req_ff;
        end
    end

    // sync fires on a request edge or on the chosen lock rising edge
    wire logic freq_rise  = freq_lock_ff & ~freq_lock_old_ff;
    wire logic phase_rise = phase_lock_ff & ~phase_lock_old_ff;
    wire logic req_rise   = sync_req_ff & ~sync_req_old_ff;
    wire cdcfg_auto_type auto_mode = cdcfg_auto_type'(autosync_ff[1:0]);
    logic auto_fire;
    always_comb begin
        unique case (auto_mode)
            CDCFG_AUTO_OFF:   auto_fire = 1'b0;
            CDCFG_AUTO_FREQ:  auto_fire = freq_rise;
            CDCFG_AUTO_PHASE: auto_fire = phase_rise;
            CDCFG_AUTO_RSVD:  auto_fire = 1'b0;
        endcase
    end
    wire logic nxt_sync_pulse = req_rise | auto_fire;

    // divider reset gated per output by the mask bits
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            sync_pulse_ff <= 1'b0;
            div_reset_ff  <= 4'h0;
        end else begin
            sync_pulse_ff <= nxt_sync_pulse;
            div_reset_ff  <= {4{nxt_sync_pulse}} & ~sync_ff[3:0];
        end
    end
    assign divider_sync_out  = sync_pulse_ff;
    assign divider_reset_out = div_reset_ff;

    // ==========================================
    // per-output decode
    for (genvar g = 0; g < CDCFG_NUM_OUTPUTS; g++) begin : g_out
        wire cdcfg_mode_type mode = cdcfg_mode_type'(chmode_ff[g][2:0]);
        wire logic is_cmos = mode == CDCFG_MODE_CMOS_BOTH
                             || mode == CDCFG_MODE_CMOS_POS
                             || mode == CDCFG_MODE_CMOS_NEG;
        assign out_ctrl_out[g].power_down   = settings_ff[g] | deep_sleep_out;
        assign out_ctrl_out[g].driver_en    = enable_ff[g] & ~settings_ff[g];
        assign out_ctrl_out[g].sync_mask    = sync_ff[g];
        assign out_ctrl_out[g].polarity_inv = chmode_ff[g][CDCFG_CH_POL_INV_BIT];
        assign out_ctrl_out[g].phase_inv    = is_cmos
                                              & chmode_ff[g][CDCFG_CH_PHASE_INV_BIT];
        assign out_ctrl_out[g].drive_strong = chmode_ff[g][CDCFG_CH_DRIVE_BIT];
        assign out_ctrl_out[g].pos_drive    = mode == CDCFG_MODE_CMOS_BOTH
                                              || mode == CDCFG_MODE_CMOS_POS;
        assign out_ctrl_out[g].neg_drive    = mode == CDCFG_MODE_CMOS_BOTH
                                              || mode == CDCFG_MODE_CMOS_NEG;
        assign out_ctrl_out[g].lvds_sel     = mode == CDCFG_MODE_LVDS;
        assign out_ctrl_out[g].lvpecl_sel   = mode == CDCFG_MODE_LVPECL;
    end
endmodule
`default_nettype wire

/* File: bench/cdcfg_chk.sv */
// checker: timing and decode relations at the ports of the clock distribution config block
`timescale 1ns/1ns
`default_nettype none
module cdcfg_chk
    import cdcfg_pkg::*;
(
    input wire logic               ref_clk_in,
    input wire logic               rst_in,
    input wire logic               reg_rd_in,
    input wire logic               sync_request_in,
    input wire logic [7:0]         reg_rdata_out,
    input wire logic               deep_sleep_out,
    input wire logic               divider_sync_out,
    input wire logic [3:0]         divider_reset_out,
    input wire cdcfg_out_ctrl_type [3:0] out_ctrl_out
);
    // ==========================================
    // per-output flags gathered from the control carrier
    logic [3:0] pd, en, msk, drv, bad;
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            pd[i] = out_ctrl_out[i].power_down;
            en[i] = out_ctrl_out[i].driver_en;
            msk[i] = out_ctrl_out[i].sync_mask;
            drv[i] = out_ctrl_out[i].pos_drive | out_ctrl_out[i].neg_drive;
            bad[i] = (out_ctrl_out[i].phase_inv & ~drv[i]) | (out_ctrl_out[i].lvds_sel & out_ctrl_out[i].lvpecl_sel)
                | ((out_ctrl_out[i].lvds_sel | out_ctrl_out[i].lvpecl_sel) & drv[i]);
        end
    end
    // ==========================================
    // assertions
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    a_rdata_idle: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
        else $error("read data outside its slot");
    a_deep_sleep: assert property (deep_sleep_out == (pd == 4'hF))
        else $error("deep sleep does not follow power-down bits");
    a_driver_off: assert property ((pd & en) == 4'h0)
        else $error("driver enabled while powered down");
    a_sync_single: assert property (divider_sync_out |=> !divider_sync_out)
        else $error("sync pulse longer than one cycle");
    a_reset_masked: assert property (divider_reset_out == (divider_sync_out ? ~msk : 4'h0))
        else $error("divider reset ignores mask");
    a_req_latency: assert property ($rose(sync_request_in) |-> ##[3:5] divider_sync_out)
        else $error("direct request gave no sync pulse");
    a_mode_decode: assert property (bad == 4'h0)
        else $error("inconsistent output mode decode");
    a_rst_tristate: assert property ($fell(rst_in) |-> drv == 4'h0 && !divider_sync_out)
        else $error("pins driven after reset");
    c_sleep: cover property (deep_sleep_out);
    c_masked: cover property (divider_sync_out && divider_reset_out != 4'hF);
    c_request: cover property ($rose(sync_request_in));
endmodule
bind cdcfg_top cdcfg_chk u_chk (.ref_clk_in, .rst_in, .reg_rd_in, .sync_request_in, .reg_rdata_out,
    .deep_sleep_out, .divider_sync_out, .divider_reset_out, .out_ctrl_out);
`default_nettype wire

/* File: bench/cdcfg_partner.sv */
// partner: lock and sync request source standing for the loop that feeds the config block
`timescale 1ns/1ns
`default_nettype none
module cdcfg_partner (
    input  wire logic       ref_clk_in,
    input  wire logic [1:0] kind_in,
    input  wire logic       go_in,
    output logic            freq_lock_out,
    output logic            phase_lock_out,
    output logic            sync_req_out
);
    int         hold = 0;
    logic [1:0] k    = 2'h0;
    // each go raises the chosen level for six cycles, then drops it so a later rise is a new event
    always @(posedge ref_clk_in) begin
        if (go_in) begin
            hold <= 6;
            k <= kind_in;
        end else if (hold > 0) begin
            hold <= hold - 1;
        end
    end
    assign sync_req_out   = hold > 0 && k == 2'h0;
    assign freq_lock_out  = hold > 0 && k == 2'h1;
    assign phase_lock_out = hold > 0 && k == 2'h2;
endmodule
`default_nettype wire

/* File: bench/cdcfg_top_tb.sv */
// testbench: register file, decode and sync checks of the clock distribution config block
`timescale 1ns/1ns
`default_nettype none
module cdcfg_top_tb
    import cdcfg_pkg::*;
;
    logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, go = 1'b0;
    logic [11:0] addr = 12'h000;
    logic [7:0]  wdat = 8'h00, rdat;
    logic [1:0]  kind = 2'h0;
    logic        fl, pl, sreq, ext, sn, ds, dsync;
    logic [3:0]  drst;
    logic [31:0] lf = 32'hD598D89A;
    cdcfg_sync_src_type ssrc;
    cdcfg_out_ctrl_type [3:0] oc;
    int n_fail = 0, tests_run = 0;
    int mdl [8];
    int wmask [8] = '{8'h3F, 8'h0F, 8'h3F, 8'h03, 8'h3F, 8'h3F, 8'h3F, 8'h3F};
    // ==========================================
    // clock, design and partner
    initial forever #50 clk = ~clk;
    cdcfg_top u_dut (.ref_clk_in(clk), .rst_in(rst), .reg_addr_in(addr), .reg_wdata_in(wdat), .reg_wr_in(wr),
        .reg_rd_in(rd), .freq_lock_in(fl), .phase_lock_in(pl), .sync_request_in(sreq), .reg_rdata_out(rdat),
        .ext_resistor_out(ext), .super_nyquist_out(sn), .deep_sleep_out(ds), .sync_source_out(ssrc),
        .divider_sync_out(dsync), .divider_reset_out(drst), .out_ctrl_out(oc));
    cdcfg_partner u_far (.ref_clk_in(clk), .kind_in(kind), .go_in(go), .freq_lock_out(fl),
        .phase_lock_out(pl), .sync_req_out(sreq));
    // ==========================================
    // helpers
    function automatic logic [31:0] nx(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdat <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        if (a >= 12'h400 && a <= 12'h407) mdl[a - 12'h400] = d & wmask[a - 12'h400];
        #1;
    endtask
    task automatic rd_reg(input logic [11:0] a);
        logic [7:0] e;
        e = (a >= 12'h400 && a <= 12'h407) ? mdl[a - 12'h400] : 8'h00;
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 cmp(rdat, e);
        @(posedge clk);
        #1 cmp(rdat, 8'h00);
    endtask
    // expected decode of every output from the bench copy of the registers
    task automatic chk_dec;
        cdcfg_out_ctrl_type e;
        int m;
        cmp(ext, mdl[0][5]);
        cmp(sn, mdl[0][4]);
        cmp(ds, mdl[0][3:0] == 15);
        cmp(ssrc, mdl[2][5:4]);
        for (int i = 0; i < 4; i++) begin
            m = mdl[4 + i][2:0];
            e.power_down = mdl[0][i] || mdl[0][3:0] == 15;
            e.driver_en = mdl[1][i] && !e.power_down;
            e.sync_mask = mdl[2][i];
            e.polarity_inv = mdl[4 + i][4];
            e.phase_inv = mdl[4 + i][5] && m < 3;
            e.drive_strong = mdl[4 + i][3];
            e.pos_drive = m == 0 || m == 1;
            e.neg_drive = m == 0 || m == 2;
            e.lvds_sel = m == 4;
            e.lvpecl_sel = m == 5;
            cmp(oc[i], e);
        end
    endtask
    // one trigger from the partner, then a bounded wait for the divider sync pulse
    task automatic sync_try(input logic [1:0] k, input logic hit);
        int n;
        @(posedge clk);
        kind <= k;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        n = 0;
        while (!dsync && n < 10) begin
            @(posedge clk);
            #1 n++;
        end
        cmp(dsync, hit);
        if (hit) cmp(drst, 4'(~mdl[2][3:0]));
        repeat (8) @(posedge clk);
    endtask
    task automatic wrap_up;
        $display("checks %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // ==========================================
    // main sequence
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        mdl = '{0, 0, 0, 0, 3, 3, 3, 3};
        for (int a = 12'h400; a <= 12'h408; a++) rd_reg(a);
        chk_dec;
        for (int j = 0; j < 40; j++) begin
            lf = nx(lf);
            wr_reg(12'h400 + lf[3:0] % 9, lf[15:8]);
            chk_dec;
            rd_reg(12'h400 + lf[19:16] % 9);
        end
        for (int m = 0; m < 8; m++) begin
            wr_reg(12'h404 + m % 4, 8'h38 | m);
            chk_dec;
        end
        wr_reg(12'h401, 8'hFF);
        wr_reg(12'h400, 8'h0F);
        chk_dec;
        wr_reg(12'h402, 8'h05);
        wr_reg(12'h403, 8'h00);
        sync_try(2'h0, 1'b1);
        sync_try(2'h1, 1'b0);
        wr_reg(12'h403, 8'h01);
        sync_try(2'h1, 1'b1);
        sync_try(2'h2, 1'b0);
        wr_reg(12'h403, 8'h02);
        sync_try(2'h2, 1'b1);
        sync_try(2'h1, 1'b0);
        wr_reg(12'h403, 8'h03);
        sync_try(2'h2, 1'b0);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        mdl = '{0, 0, 0, 0, 3, 3, 3, 3};
        rd_reg(12'h404);
        chk_dec;
        wrap_up;
    end
endmodule
`default_nettype wire
